// ===== hdl/receiver_setup_pkg.sv
/*
 * Constants for the event receiver setup handler: register map,
 * notify modes, result codes, protocol kinds, interrupt bits, timing.
 * Assumes a single 20 MHz clock and an AHB-Lite register slave.
 */
// Operation
// - wrong protocol kind: reject, change nothing, answer invalid-protocol code
// - receiver locator length and layout follow the protocol kind
// - protocol kind 0x00: locator is exactly one endpoint number byte
// - vendor kind: locator starts with a 32-bit enterprise number
// - keepalive mode: tick event every keepalive_period_s seconds
// - period too short to sustain: answer keepalive_rate_excess code
// - unsupported notify mode: answer the mode-not-supported code
// - answer is one result byte; invalid protocol is 0x80
// - disable mode accepts kind and locator bytes but ignores them
// - keepalive mode also acts as push notify
// - each accepted request replaces mode and period; a disable request keeps kind and locator
// - only one receiver locator is stored at a time
package receiver_setup_pkg;

    // register byte offsets
    localparam int        OFF_W          = 8;
    localparam bit [7:0]  OFF_REQ_BYTE   = 8'h00;
    localparam bit [7:0]  OFF_REQ_END    = 8'h04;
    localparam bit [7:0]  OFF_RESULT     = 8'h08;
    localparam bit [7:0]  OFF_STATUS     = 8'h0C;
    localparam bit [7:0]  OFF_LOCATOR    = 8'h10;
    localparam bit [7:0]  OFF_CAPS       = 8'h14;
    localparam bit [7:0]  OFF_IRQ_STAT   = 8'h18;
    localparam bit [7:0]  OFF_IRQ_MASK   = 8'h1C;

    // notify_mode_select codes
    localparam bit [7:0]  MODE_DISABLE   = 8'h00;
    localparam bit [7:0]  MODE_PUSH      = 8'h01;
    localparam bit [7:0]  MODE_POLLED    = 8'h02;
    localparam bit [7:0]  MODE_KEEPALIVE = 8'h03;

    // result codes
    localparam bit [7:0]  RC_SUCCESS     = 8'h00;
    localparam bit [7:0]  RC_BAD_LENGTH  = 8'h03;
    localparam bit [7:0]  RC_BAD_PROTO   = 8'h80;
    localparam bit [7:0]  RC_MODE_UNSUP  = 8'h81;
    localparam bit [7:0]  RC_RATE_EXCESS = 8'h82;

    // link protocol kinds
    localparam bit [7:0]  KIND_MCTP      = 8'h00;
    localparam bit [7:0]  KIND_VENDOR    = 8'hFF;

    // request layout, in bytes
    localparam bit [7:0]  HEAD_LEN       = 8'h02;
    localparam bit [7:0]  PERIOD_LEN     = 8'h02;
    localparam bit [7:0]  MCTP_LOC_LEN   = 8'h01;
    localparam bit [7:0]  VENDOR_LOC_MIN = 8'h04;
    localparam bit [7:0]  OTHER_LOC_MIN  = 8'h01;
    localparam bit [7:0]  LEN_MAX        = 8'hFF;

    // caps register layout and reset
    localparam int        CAP_MODES_LSB  = 0;
    localparam int        CAP_KIND_LSB   = 8;
    localparam int        CAP_MINP_LSB   = 16;
    localparam bit [3:0]  CAP_MODES_RST  = 4'hF;
    localparam bit [15:0] CAP_MINP_RST   = 16'h0001;

    // status register layout
    localparam int        ST_VALID_BIT   = 4;
    localparam int        ST_KIND_LSB    = 8;
    localparam int        ST_PERIOD_LSB  = 16;

    // interrupt bits
    localparam int        IRQ_W          = 3;
    localparam int        IRQ_TICK       = 0;
    localparam int        IRQ_ACCEPT     = 1;
    localparam int        IRQ_REJECT     = 2;

    // bus answer
    localparam bit        RESP_OKAY      = 1'b0;

    // timing: one second at the system clock
    localparam longint    SECOND_NS      = 1000000000;
    localparam longint    CLK_PERIOD_NS  = 50;
    localparam int        SECOND_CYCLES  = int'(SECOND_NS / CLK_PERIOD_NS);

endpackage

// ===== hdl/pulse_divider.sv
/*
 * Divider that turns the system clock into a one-cycle enable pulse
 * every LIMIT cycles while enabled.
 * Assumes a synchronised active-low reset from the instantiating block.
 */
module pulse_divider #(
    parameter int unsigned LIMIT = 20000000
) (
    input  wire logic clk_sys,
    input  wire logic srst_n,
    input  wire logic restart,
    input  wire logic enable,
    output logic      pulse_q
);
    localparam int W = $clog2(LIMIT + 1);
    localparam logic [W-1:0] LAST = W'(LIMIT - 1);

    logic [W-1:0] cnt_q;
    wire          at_last = (cnt_q == LAST);

    // phase restarts so the first pulse is a full period away
    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            cnt_q   <= '0;
            pulse_q <= 1'b0;
        end else if (restart || !enable) begin
            cnt_q   <= '0;
            pulse_q <= 1'b0;
        end else begin
            cnt_q   <= at_last ? '0 : cnt_q + W'(1);
            pulse_q <= at_last;
        end
    end
endmodule

// ===== hdl/keepalive_timer.sv
/*
 * Seconds counter for the keepalive tick: counts one-second pulses and
 * fires a one-cycle tick each time the programmed period has passed.
 * Assumes sec_pulse comes from a divider on the same clock.
 */
module keepalive_timer (
    input  wire logic        clk_sys,
    input  wire logic        srst_n,
    input  wire logic        restart,
    input  wire logic        run,
    input  wire logic        sec_pulse,
    input  wire logic [15:0] period,
    output logic             tick_q
);
    logic [15:0] secs_q;
    wire  [16:0] secs_next = {1'b0, secs_q} + 17'h00001;
    wire         elapsed   = sec_pulse && (secs_next >= {1'b0, period});

    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            secs_q <= '0;
            tick_q <= 1'b0;
        end else if (restart || !run) begin
            secs_q <= '0;
            tick_q <= 1'b0;
        end else if (elapsed) begin
            secs_q <= '0;
            tick_q <= 1'b1;
        end else begin
            secs_q <= sec_pulse ? secs_next[15:0] : secs_q;
            tick_q <= 1'b0;
        end
    end
endmodule

// ===== hdl/event_receiver_setup_handler.sv
/*
 * Event receiver setup handler. Software pushes the request bytes one
 * by one, then writes the end register; the block checks the request,
 * stores the accepted settings, produces a one-byte result code and
 * runs the keepalive tick.
 * Assumes an AHB-Lite master on the same clock, single word transfers,
 * and a message sender that consumes the tick and settings outputs.
 */
module event_receiver_setup_handler #(
    parameter int unsigned SEC_CYCLES = receiver_setup_pkg::SECOND_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic [1:0]       notify_mode_select,
    output logic             push_active,
    output logic             polled_active,
    output logic [7:0]       link_protocol_kind,
    output logic [31:0]      receiver_locator,
    output logic             locator_valid,
    output logic [15:0]      keepalive_period_s,
    output logic             keepalive_tick_event,
    output logic             irq
);
    import receiver_setup_pkg::*;

    // reset release
    logic rst_meta_q;
    logic srst_n;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'b0;
            srst_n     <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            srst_n     <= rst_meta_q;
        end
    end

    // bus address phase
    wire             ap_take = hsel && htrans[1] && hready;
    wire [OFF_W-1:0] ap_off  = haddr[OFF_W-1:0];
    wire             ap_hit  = (haddr[31:OFF_W] == '0);
    wire             rd_take = ap_take && !hwrite;

    logic             wr_pend_q;
    logic [OFF_W-1:0] wr_off_q;
    logic             wr_hit_q;

    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            wr_pend_q <= 1'b0;
            wr_off_q  <= '0;
            wr_hit_q  <= 1'b0;
        end else if (hready) begin
            wr_pend_q <= ap_take && hwrite;
            wr_off_q  <= ap_off;
            wr_hit_q  <= ap_hit;
        end
    end

    // data phase write decode
    wire wr_ok   = wr_pend_q && wr_hit_q;
    wire wr_byte = wr_ok && (wr_off_q == OFF_REQ_BYTE);
    wire wr_end  = wr_ok && (wr_off_q == OFF_REQ_END);
    wire wr_caps = wr_ok && (wr_off_q == OFF_CAPS);
    wire wr_mask = wr_ok && (wr_off_q == OFF_IRQ_MASK);
    wire [7:0] wr_b = hwdata[7:0];

    // request bytes as they arrive
    logic [7:0]  len_q;
    logic [7:0]  mode_byte_q;
    logic [7:0]  kind_byte_q;
    logic [31:0] loc_acc_q;
    logic [7:0]  hb_prev_q;
    logic [7:0]  hb_last_q;

    wire       len_full = (len_q == LEN_MAX);
    wire [7:0] loc_idx  = len_q - HEAD_LEN;
    wire       in_loc   = (len_q >= HEAD_LEN) &&
                          (loc_idx < VENDOR_LOC_MIN);

    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            len_q       <= '0;
            mode_byte_q <= '0;
            kind_byte_q <= '0;
            hb_prev_q   <= '0;
            hb_last_q   <= '0;
        end else if (wr_end) begin
            len_q <= '0;
        end else if (wr_byte) begin
            // oversize requests saturate at 255; the locator length check fails them only for kind 0x00
            len_q     <= len_full ? len_q : len_q + 8'h01;
            hb_prev_q <= hb_last_q;
            hb_last_q <= wr_b;
            if (len_q == 8'h00) begin
                mode_byte_q <= wr_b;
            end
            if (len_q == 8'h01) begin
                kind_byte_q <= wr_b;
            end
        end
    end

    // locator bytes, little-endian, first four only
    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            loc_acc_q <= '0;
        end else if (wr_end) begin
            loc_acc_q <= '0;
        end else if (wr_byte && in_loc) begin
            loc_acc_q[loc_idx[1:0]*8 +: 8] <= wr_b;
        end
    end

    // capability and mask registers
    logic [3:0]       cap_modes_q;
    logic [7:0]       cap_kind_q;
    logic [15:0]      cap_minp_q;
    logic [IRQ_W-1:0] irq_mask_q;

    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            cap_modes_q <= CAP_MODES_RST;
            cap_kind_q  <= KIND_MCTP;
            cap_minp_q  <= CAP_MINP_RST;
            irq_mask_q  <= '0;
        end else begin
            if (wr_caps) begin
                cap_modes_q <= hwdata[CAP_MODES_LSB +: 4];
                cap_kind_q  <= hwdata[CAP_KIND_LSB +: 8];
                cap_minp_q  <= hwdata[CAP_MINP_LSB +: 16];
            end
            if (wr_mask) begin
                irq_mask_q <= hwdata[IRQ_W-1:0];
            end
        end
    end

    // request check
    wire        is_ka     = (mode_byte_q == MODE_KEEPALIVE);
    wire        is_off    = (mode_byte_q == MODE_DISABLE);
    wire [7:0]  tail_len  = is_ka ? PERIOD_LEN : 8'h00;
    wire [8:0]  fixed_len = {1'b0, HEAD_LEN} + {1'b0, tail_len};
    wire [8:0]  have_len  = {1'b0, len_q};
    wire [15:0] period_in = {hb_last_q, hb_prev_q};

    wire too_short = (len_q < HEAD_LEN);
    wire mode_ok   = (mode_byte_q <= MODE_KEEPALIVE) &&
                     cap_modes_q[mode_byte_q[1:0]];
    wire kind_ok   = (kind_byte_q == cap_kind_q);
    wire is_mctp   = (kind_byte_q == KIND_MCTP);
    wire is_vendor = (kind_byte_q == KIND_VENDOR);

    // locator length keyed on the protocol kind
    wire len_mctp  = have_len == fixed_len + {1'b0, MCTP_LOC_LEN};
    wire len_vend  = have_len >= fixed_len + {1'b0, VENDOR_LOC_MIN};
    wire len_other = have_len >= fixed_len + {1'b0, OTHER_LOC_MIN};
    wire loc_ok    = is_mctp   ? len_mctp :
                     is_vendor ? len_vend : len_other;
    wire rate_ok   = (period_in != 16'h0000) &&
                     (period_in >= cap_minp_q);

    // result priority: length, mode, disable, protocol, locator, rate
    wire [7:0] eval_rc =
        too_short  ? RC_BAD_LENGTH  :
        !mode_ok   ? RC_MODE_UNSUP  :
        is_off     ? RC_SUCCESS     :
        !kind_ok   ? RC_BAD_PROTO   :
        !loc_ok    ? RC_BAD_LENGTH  :
        (is_ka && !rate_ok) ? RC_RATE_EXCESS :
        RC_SUCCESS;

    wire accept = wr_end && (eval_rc == RC_SUCCESS);
    wire reject = wr_end && (eval_rc != RC_SUCCESS);

    // the single response byte
    logic [7:0] result_q;

    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            result_q <= RC_SUCCESS;
        end else if (wr_end) begin
            result_q <= eval_rc;
        end
    end

    // stored settings; a rejected request leaves them untouched
    logic [1:0]  mode_q;
    logic [7:0]  kind_q;
    logic [31:0] locator_q;
    logic        valid_q;
    logic [15:0] period_q;

    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            mode_q    <= MODE_DISABLE[1:0];
            kind_q    <= KIND_MCTP;
            locator_q <= '0;
            valid_q   <= 1'b0;
            period_q  <= '0;
        end else if (accept) begin
            mode_q   <= mode_byte_q[1:0];
            period_q <= is_ka ? period_in : 16'h0000;
            if (!is_off) begin
                // one locator only, overwritten whole
                kind_q    <= kind_byte_q;
                locator_q <= is_mctp ? {24'h000000, loc_acc_q[7:0]}
                                     : loc_acc_q;
                valid_q   <= 1'b1;
            end
        end
    end

    // keepalive timing
    wire ka_run = (mode_q == MODE_KEEPALIVE[1:0]);
    wire sec_pulse;
    wire tick;

    pulse_divider #(
        .LIMIT   (SEC_CYCLES)
    ) u_sec_div (
        .clk_sys (clk_sys),
        .srst_n  (srst_n),
        .restart (accept),
        .enable  (ka_run),
        .pulse_q (sec_pulse)
    );

    keepalive_timer u_ka_timer (
        .clk_sys   (clk_sys),
        .srst_n    (srst_n),
        .restart   (accept),
        .run       (ka_run),
        .sec_pulse (sec_pulse),
        .period    (period_q),
        .tick_q    (tick)
    );

    // interrupts: sticky, cleared by reading, set beats clear
    logic [IRQ_W-1:0] irq_stat_q;

    wire rd_stat = rd_take && ap_hit && (ap_off == OFF_IRQ_STAT);
    wire [IRQ_W-1:0] irq_ev   = {reject, accept, tick};
    wire [IRQ_W-1:0] irq_keep = rd_stat ? '0 : irq_stat_q;

    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= irq_keep | irq_ev;
        end
    end

    // read data, taken in the address phase
    wire [31:0] status_w = {period_q, kind_q, 3'h0, valid_q,
                            2'h0, mode_q};
    wire [31:0] caps_w   = {cap_minp_q, cap_kind_q, 4'h0, cap_modes_q};
    wire [31:0] rd_mux   =
        !ap_hit                    ? 32'h00000000 :
        (ap_off == OFF_RESULT)     ? {24'h000000, result_q} :
        (ap_off == OFF_STATUS)     ? status_w :
        (ap_off == OFF_LOCATOR)    ? locator_q :
        (ap_off == OFF_CAPS)       ? caps_w :
        (ap_off == OFF_IRQ_STAT)   ? {29'h00000000, irq_stat_q} :
        (ap_off == OFF_IRQ_MASK)   ? {29'h00000000, irq_mask_q} :
        32'h00000000;

    logic [31:0] hrdata_q;

    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            hrdata_q <= '0;
        end else if (rd_take) begin
            hrdata_q <= rd_mux;
        end
    end

    // zero wait states; every access answers OKAY
    assign hreadyout            = 1'b1;
    assign hresp                = RESP_OKAY;
    assign hrdata               = hrdata_q;
    assign notify_mode_select   = mode_q;
    assign push_active          = (mode_q == MODE_PUSH[1:0]) ||
                                  ka_run;
    assign polled_active        = (mode_q == MODE_POLLED[1:0]);
    assign link_protocol_kind   = kind_q;
    assign receiver_locator     = locator_q;
    assign locator_valid        = valid_q;
    assign keepalive_period_s   = period_q;
    assign keepalive_tick_event = tick;
    assign irq                  = |(irq_stat_q & irq_mask_q);

endmodule

// ===== sim/receiver_setup_sva.sv
/* Checker for the event receiver setup handler, bound to its ports.
 * Assumes one clock domain and hready tied to hreadyout. */
module receiver_setup_sva #(
    parameter int unsigned SEC_CYCLES = receiver_setup_pkg::SECOND_CYCLES
) (
    input wire logic        clk_sys,
    input wire logic        rstn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [1:0]  notify_mode_select,
    input wire logic        push_active,
    input wire logic [7:0]  link_protocol_kind,
    input wire logic [31:0] receiver_locator,
    input wire logic        locator_valid,
    input wire logic [15:0] keepalive_period_s,
    input wire logic        keepalive_tick_event
);
    import receiver_setup_pkg::*;
    // gap only judged between two ticks with no request end between them
    logic        end_wr_q;
    logic        armed_q;
    logic [31:0] gap_q;
    wire logic        end_take = hsel && htrans[1] && hready && hwrite &&
                                 haddr == {24'h0, OFF_REQ_END};
    wire logic [31:0] span = 32'(keepalive_period_s) * 32'(SEC_CYCLES);
    wire logic        tick = keepalive_tick_event;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            end_wr_q <= 1'b0;
            armed_q  <= 1'b0;
            gap_q    <= 32'h0;
        end else begin
            end_wr_q <= end_take;
            armed_q  <= !end_wr_q && (tick || armed_q);
            gap_q    <= tick ? 32'h0 : gap_q + 32'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    property p_push;
        push_active == (notify_mode_select == 2'h1 ||
                        notify_mode_select == 2'h3);
    endproperty
    property p_tick_pulse;
        tick |=> !tick;
    endproperty
    property p_tick_mode;
        tick |-> notify_mode_select == 2'h3;
    endproperty
    property p_period_set;
        notify_mode_select == 2'h3 |-> keepalive_period_s != 16'h0;
    endproperty
    property p_change_cause;
        ($changed(notify_mode_select) || $changed(link_protocol_kind) ||
         $changed(receiver_locator) || $changed(keepalive_period_s))
        |-> $past(end_wr_q);
    endproperty
    property p_tick_gap;
        tick && armed_q |-> gap_q == span - 32'h1;
    endproperty
    property p_tick_due;
        armed_q && notify_mode_select == 2'h3 |-> gap_q < span;
    endproperty
    property p_valid_hold;
        locator_valid |=> locator_valid;
    endproperty
    property p_valid_rise;
        $rose(locator_valid) |-> $past(end_wr_q) && notify_mode_select != 2'h0;
    endproperty
    a_push: assert property (p_push)
        else $error("push flag does not follow mode");
    a_tick_pulse: assert property (p_tick_pulse)
        else $error("tick longer than one cycle");
    a_tick_mode: assert property (p_tick_mode)
        else $error("tick outside keepalive mode");
    a_period_set: assert property (p_period_set)
        else $error("keepalive with zero period");
    a_change_cause: assert property (p_change_cause)
        else $error("settings changed without request end");
    a_tick_gap: assert property (p_tick_gap)
        else $error("tick spacing wrong");
    a_tick_due: assert property (p_tick_due)
        else $error("tick overdue");
    a_valid_hold: assert property (p_valid_hold)
        else $error("locator valid dropped");
    a_valid_rise: assert property (p_valid_rise)
        else $error("locator valid without accepted request");
    c_tick: cover property (tick && armed_q);
    c_valid: cover property ($rose(locator_valid));
    c_end: cover property (end_wr_q ##1 $changed(receiver_locator));
endmodule

bind event_receiver_setup_handler receiver_setup_sva #(
    .SEC_CYCLES(SEC_CYCLES)
) receiver_setup_sva_i (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .notify_mode_select(notify_mode_select), .push_active(push_active),
    .link_protocol_kind(link_protocol_kind),
    .receiver_locator(receiver_locator), .locator_valid(locator_valid),
    .keepalive_period_s(keepalive_period_s),
    .keepalive_tick_event(keepalive_tick_event)
);

// ===== sim/event_sink.sv
/* Event receiver model: takes keepalive ticks and times their spacing.
 * Assumes the tick is a one-cycle pulse on clk_sys. */
module event_sink (
    input  wire logic clk_sys,
    input  wire logic keepalive_tick_event,
    input  wire logic push_active,
    output int        tick_count,
    output int        last_gap
);
    timeunit 1ns;
    timeprecision 1ns;
    int since;
    // ticks only count while pushing is on
    always @(posedge clk_sys) begin
        since <= since + 1;
        if (keepalive_tick_event && push_active) begin
            tick_count <= tick_count + 1;
            last_gap <= since + 1;
            since <= 0;
        end
    end
endmodule

// ===== sim/testbench.sv
/* Bench for the event receiver setup handler: builds requests over the
 * register bus, judges results, settings, interrupt and ticks.
 * Assumes the handler, checker and event sink are compiled before. */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import receiver_setup_pkg::*;
    localparam int unsigned SEC = 20;
    typedef logic [7:0] bytes_t[$];
    logic        clk_sys, hreadyout, hresp, push_active, polled_active;
    logic        rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        locator_valid, tick, irq;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, locator;
    logic [1:0]  htrans = 2'h0, mode;
    logic [2:0]  hsize = 3'h2;
    logic [7:0]  kind;
    logic [15:0] period;
    int          err_count = 0, samples_checked = 0, cyc = 0, t_end = 0;
    int          tick_count, last_gap;
    event_receiver_setup_handler #(
        .SEC_CYCLES(SEC)
    ) event_receiver_setup_handler_i (
        .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .notify_mode_select(mode),
        .push_active(push_active), .polled_active(polled_active),
        .link_protocol_kind(kind), .receiver_locator(locator),
        .locator_valid(locator_valid), .keepalive_period_s(period),
        .keepalive_tick_event(tick), .irq(irq)
    );
    event_sink event_sink_i (
        .clk_sys(clk_sys), .keepalive_tick_event(tick),
        .push_active(push_active), .tick_count(tick_count),
        .last_gap(last_gap)
    );
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) cyc <= cyc + 1;
    function automatic logic [31:0] a32(input logic [7:0] o);
        return {24'h0, o};
    endfunction
    task check(input string name, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // ready is sampled even though this slave never stalls
    task bus_xfer(input logic [31:0] a, input logic w, inout logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        if (!w) d = hrdata;
    endtask
    task bus_wr(input logic [31:0] a, d);
        logic [31:0] x;
        x = d;
        bus_xfer(a, 1'b1, x);
    endtask
    task bus_rd(input logic [31:0] a, output logic [31:0] d);
        d = 32'h0;
        bus_xfer(a, 1'b0, d);
    endtask
    task send_req(input bytes_t b, input logic [7:0] rc);
        logic [31:0] s0, s1, d;
        bus_rd(a32(OFF_STATUS), s0);
        foreach (b[i]) bus_wr(a32(OFF_REQ_BYTE), {24'h0, b[i]});
        bus_wr(a32(OFF_REQ_END), 32'h0);
        t_end = cyc;
        bus_rd(a32(OFF_RESULT), d);
        check("result", d, {24'h0, rc});
        bus_rd(a32(OFF_STATUS), s1);
        if (rc != RC_SUCCESS) check("kept", s1, s0);
    endtask
    task wait_tick(output int n);
        int c0;
        c0 = tick_count;
        while (tick_count == c0 && cyc - t_end < 1000) @(posedge clk_sys);
        n = cyc - t_end - 2; // count lags the tick by two edges
    endtask
    task test_reset;
        logic [31:0] d;
        bus_rd(a32(OFF_CAPS), d);
        check("caps", d, {CAP_MINP_RST, KIND_MCTP, 4'h0, CAP_MODES_RST});
        bus_rd(a32(OFF_STATUS), d);
        check("status", d, 32'h0);
        bus_rd(a32(OFF_IRQ_MASK), d);
        check("mask", d, 32'h0);
        bus_wr(a32(8'h40), 32'hFFFF_FFFF);
        bus_rd(a32(8'h40), d);
        check("unmapped", d, 32'h0);
        $display("test reset done");
    endtask
    task test_keepalive;
        logic [31:0] d;
        int n;
        bus_wr(a32(OFF_IRQ_MASK), 32'h1);
        send_req('{MODE_KEEPALIVE, KIND_MCTP, 8'h2A, 8'h02, 8'h00}, 8'h0);
        check("mode", 32'(mode), 32'h3);
        check("push", 32'(push_active), 32'h1);
        check("loc", locator, 32'h2A);
        check("valid", 32'(locator_valid), 32'h1);
        check("period", 32'(period), 32'h2);
        wait_tick(n);
        check("first", 32'(n >= 2 * SEC && n <= 2 * SEC + 2), 32'h1);
        check("irq", 32'(irq), 32'h1);
        bus_rd(a32(OFF_IRQ_STAT), d);
        check("stat", d, 32'h3);
        bus_rd(a32(OFF_IRQ_STAT), d);
        check("stat clr", d, 32'h0);
        check("irq clr", 32'(irq), 32'h0);
        wait_tick(n);
        check("gap", 32'(last_gap), 32'(2 * SEC));
        repeat (SEC) @(posedge clk_sys);
        send_req('{MODE_KEEPALIVE, KIND_MCTP, 8'h2A, 8'h02, 8'h00}, 8'h0);
        wait_tick(n);
        check("restart", 32'(n >= 2 * SEC && n <= 2 * SEC + 2), 32'h1);
        $display("test keepalive done");
    endtask
    task test_rejects;
        logic [31:0] d;
        bus_wr(a32(OFF_IRQ_MASK), 32'h4);
        send_req('{8'h03, 8'h01, 8'h2A, 8'h02, 8'h00}, RC_BAD_PROTO);
        check("irq rej", 32'(irq), 32'h1);
        bus_rd(a32(OFF_IRQ_STAT), d);
        check("stat rej", d & 32'h4, 32'h4);
        check("irq rej clr", 32'(irq), 32'h0);
        send_req('{8'h04, 8'h00, 8'h2A}, RC_MODE_UNSUP);
        send_req('{8'h03, 8'h00, 8'h2A, 8'h00, 8'h00}, RC_RATE_EXCESS);
        send_req('{8'h01, 8'h00, 8'h2A, 8'h2B}, RC_BAD_LENGTH);
        send_req('{8'h01}, RC_BAD_LENGTH);
        bus_wr(a32(OFF_CAPS), 32'h0003_0007);
        send_req('{8'h03, 8'h00, 8'h2A, 8'h03, 8'h00}, RC_MODE_UNSUP);
        bus_wr(a32(OFF_CAPS), 32'h0003_FF0F);
        send_req('{8'h03, 8'hFF, 8'h78, 8'h56, 8'h34, 8'h12, 8'h02, 8'h00},
                 RC_RATE_EXCESS);
        send_req('{8'h01, 8'hFF, 8'h01, 8'h02, 8'h03}, RC_BAD_LENGTH);
        send_req('{8'h01, 8'hFF, 8'h78, 8'h56, 8'h34, 8'h12}, 8'h0);
        check("vendor loc", locator, 32'h1234_5678);
        check("vendor kind", 32'(kind), 32'hFF);
        check("push only", 32'(period), 32'h0);
        $display("test rejects done");
    endtask
    task test_disable;
        int n;
        send_req('{MODE_DISABLE, 8'h07}, RC_SUCCESS);
        check("dis mode", 32'(mode), 32'h0);
        check("dis loc", locator, 32'h1234_5678);
        check("dis push", 32'(push_active), 32'h0);
        send_req('{MODE_POLLED, KIND_VENDOR, 8'h0D, 8'h0C, 8'h0B, 8'h0A},
                 RC_SUCCESS);
        check("one loc", locator, 32'h0A0B_0C0D);
        check("polled", 32'(polled_active), 32'h1);
        n = tick_count;
        repeat (3 * SEC) @(posedge clk_sys);
        check("no tick", 32'(tick_count), 32'(n));
        $display("test disable done");
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        test_reset;
        test_keepalive;
        test_rejects;
        test_disable;
        report_and_stop;
    end
    // far above the few hundred cycles each test needs
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        report_and_stop;
    end
endmodule
